// [hdl/lfro_consts.vh]
// Purpose: Shared constants for the low-frequency oscillator and reference clock block
// Assumes: Included by bare name; definitions only
// Notes:   Register offsets here are plain-port addresses
`ifndef LFRO_CONSTS_VH
`define LFRO_CONSTS_VH

// ==========================================================
// Register map
`define LFRO_ADDR_W            4
`define LFRO_REG_REFCTL        4'h0
`define LFRO_REG_OSCCTL        4'h1
`define LFRO_REG_STATUS        4'h2

// ==========================================================
// Reference control fields
`define LFRO_REF_EN_BIT        15
`define LFRO_REF_SLP_BIT       13
`define LFRO_REF_BASE_BIT      12
`define LFRO_REF_DIV_HI        11
`define LFRO_REF_DIV_LO        8
`define LFRO_REF_WMASK         16'hbf00
`define LFRO_REF_RESET         16'h0000

// ==========================================================
// Oscillator control fields
`define LFRO_OSC_POSC_KEEP_BIT 2
`define LFRO_OSC_LOW_FREQ_SECONDARY_OSC_EN_BIT   1
`define LFRO_OSC_WMASK         16'h0006
`define LFRO_OSC_RESET         16'h0000

// ==========================================================
// Primary oscillator modes
`define LFRO_PMODE_EC          2'h0
`define LFRO_PMODE_XT          2'h1
`define LFRO_PMODE_HS          2'h2
`define LFRO_PMODE_NONE        2'h3

// ==========================================================
// Timing
`define LFRO_DIV_W             15
`define LFRO_DIV_MAX_CODE      4'hf

`endif

// [hdl/lfro_divider.v]
// Purpose: Power-of-two divider for the reference clock output
// Assumes: Base clock arrives as a one-cycle enable pulse per base rising edge
// Notes:   Output toggles on counter rollover, giving 50% duty
`timescale 1ns/100ps
`default_nettype none
`include "lfro_consts.vh"

module lfro_divider #(
    parameter CNT_W = `LFRO_DIV_W
) (
    // Clock and reset
    input  wire             mclk_in,
    input  wire             reset_in,
    // Control
    input  wire             run_in,
    input  wire [3:0]       code_in,
    input  wire             base_tick_in,
    input  wire             base_level_in,
    // Result
    output reg              clk_out
);

    reg  [CNT_W-1:0] cnt_ff;
    reg  [CNT_W-1:0] nxt_cnt;
    reg              nxt_clk;
    reg  [CNT_W-1:0] limit;

    // ==========================================================
    // Half-period limit: divide by 2^N means toggle every 2^(N-1) ticks
    always @* begin
        limit = {CNT_W{1'b0}};
        if (code_in != 4'h0) begin
            limit = ({{(CNT_W-1){1'b0}}, 1'b1} << (code_in - 4'h1)) - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @* begin
        nxt_cnt = cnt_ff;
        nxt_clk = clk_out;
        if (!run_in) begin
            nxt_cnt = {CNT_W{1'b0}};
            nxt_clk = 1'b0;
        end else if (code_in == 4'h0) begin
            nxt_clk = base_level_in;                      // [RQ17]
            nxt_cnt = {CNT_W{1'b0}};
        end else if (base_tick_in) begin
            if (cnt_ff >= limit) begin                    // [RQ6]
                nxt_cnt = {CNT_W{1'b0}};
                nxt_clk = ~clk_out;
            end else begin
                nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge mclk_in) begin
        if (reset_in) begin
            cnt_ff  <= {CNT_W{1'b0}};
            clk_out <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            clk_out <= nxt_clk;
        end
    end

endmodule
`default_nettype wire

// [hdl/lfro_top.v]
// Purpose: Low-frequency oscillator control and programmable reference clock output
// Assumes: All inputs synchronous to mclk_in; clocks arrive as sampled levels
// Notes:   Register port: read data one cycle after read strobe
//
// Operation
// RQ1: Secondary oscillator runs whenever a consumer module requests it.
// RQ2: Enable bit starts the secondary oscillator ahead of consumers.
// RQ3: Oscillator usable only with pin-select set; else pins are digital inputs.
// RQ4: External clock mode feeds consumers from external pin; driver off, enable ignored.
// RQ5: Output enable bit puts divided reference clock on the pin.
// RQ6: Divider code N from 1 to 15 divides by two to the N.
// RQ7: Base select one picks primary oscillator; zero picks system clock.
// RQ8: Sleep-run bit keeps reference running in Sleep; else output stops.
// RQ9: Software sets sleep-run and base select and a primary mode for Sleep.
// RQ10: Primary oscillator powers down in Sleep unless sleep-keep bit set.
// RQ11: With system clock base, output follows system clock changes.
// RQ12: Bit 14 and bits 7 to 0 read zero, ignore writes.
// RQ13: Fixed half-rate clock pin in some modes; reference works in all.
// RQ14: Secondary oscillator duty should stay within 15 percent of half.
// RQ15: Enable bit set enables secondary oscillator; clear leaves it off unless requested.
// RQ16: Sleep-keep bit set keeps primary oscillator in Sleep; clear disables it.
// RQ17: Divider code zero passes base clock undivided.
// RQ18: Reset clears every implemented reference control bit.
`timescale 1ns/100ps
`default_nettype none
`include "lfro_consts.vh"

module lfro_top #(
    parameter DIV_W = `LFRO_DIV_W
) (
    // Clock and reset
    input  wire        mclk_in,
    input  wire        reset_in,
    // Register port
    input  wire [3:0]  reg_addr_in,
    input  wire [15:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [15:0] reg_rdata_out,
    // Configuration bits
    input  wire        low_freq_osc_pin_select_in,
    input  wire        ext_clock_mode_in,
    input  wire [1:0]  primary_mode_in,
    input  wire        fixed_clock_out_mode_in,
    // Device state and consumer requests
    input  wire        sleep_in,
    input  wire        real_time_calendar_req_in,
    input  wire        first_timer_req_in,
    input  wire        deep_sleep_watchdog_req_in,
    // Clock sources as sampled levels
    input  wire        sys_clk_level_in,
    input  wire        primary_osc_level_in,
    input  wire        low_freq_secondary_osc_crystal_level_in,
    input  wire        ext_low_freq_clock_in,
    input  wire        low_freq_secondary_osc_pin_a_in,
    input  wire        low_freq_secondary_osc_pin_b_in,
    // Oscillator controls
    output reg         low_freq_secondary_osc_driver_en_out,
    output reg         low_freq_secondary_osc_clk_out,
    output reg         primary_osc_run_out,
    output reg  [1:0]  low_freq_secondary_osc_pin_digital_out,
    // Output pins
    output reg         ref_clock_pin_out,
    output reg         ref_clock_pin_oe_out,
    output reg         fixed_clock_out_pin_out,
    output reg         fixed_clock_out_pin_oe_out
);

    reg  [15:0] ref_ctl_ff;
    reg  [1:0]  osc_ctl_ff;
    reg         sys_prev_ff;
    reg         posc_prev_ff;
    reg         sys_tick;
    reg         posc_tick;
    reg         base_tick;
    reg         base_level;
    reg         ref_run;
    reg         low_freq_secondary_osc_want;
    reg  [15:0] nxt_rdata;
    wire        div_clk;

    wire        ref_en    = ref_ctl_ff[`LFRO_REF_EN_BIT];
    wire        ref_slp   = ref_ctl_ff[`LFRO_REF_SLP_BIT];
    wire        ref_base  = ref_ctl_ff[`LFRO_REF_BASE_BIT];
    wire [3:0]  ref_div   = ref_ctl_ff[`LFRO_REF_DIV_HI:`LFRO_REF_DIV_LO];
    wire        posc_keep = osc_ctl_ff[1];
    wire        low_freq_secondary_osc_en   = osc_ctl_ff[0];
    wire        posc_mode = (primary_mode_in != `LFRO_PMODE_NONE);

    // ==========================================================
    // Rising edge of a sampled clock level, shared by both bases
    function rise_of;
        input cur;
        input prev;
        begin
            rise_of = cur & ~prev;
        end
    endfunction

    // ==========================================================
    // Register writes
    always @(posedge mclk_in) begin
        if (reset_in) begin
            ref_ctl_ff <= `LFRO_REF_RESET;                         // [RQ18]
            osc_ctl_ff <= 2'h0;
        end else if (reg_wr_in) begin
            if (reg_addr_in == `LFRO_REG_REFCTL) begin
                ref_ctl_ff <= reg_wdata_in & `LFRO_REF_WMASK;      // [RQ12]
            end
            if (reg_addr_in == `LFRO_REG_OSCCTL) begin
                osc_ctl_ff <= {reg_wdata_in[`LFRO_OSC_POSC_KEEP_BIT],
                               reg_wdata_in[`LFRO_OSC_LOW_FREQ_SECONDARY_OSC_EN_BIT]};
            end
        end
    end

    // ==========================================================
    // Register reads; unmapped addresses return zero
    always @* begin
        nxt_rdata = 16'h0000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `LFRO_REG_REFCTL: nxt_rdata = ref_ctl_ff;          // [RQ12]
                `LFRO_REG_OSCCTL: nxt_rdata = {13'h0000, posc_keep, low_freq_secondary_osc_en, 1'b0};
                `LFRO_REG_STATUS: nxt_rdata = {11'h000, ref_run, primary_osc_run_out,
                                               low_freq_secondary_osc_driver_en_out, low_freq_secondary_osc_want,
                                               ref_clock_pin_out};
                default:          nxt_rdata = 16'h0000;
            endcase
        end
    end

    // ==========================================================
    // Secondary oscillator control
    always @* begin
        low_freq_secondary_osc_want = real_time_calendar_req_in | first_timer_req_in
                  | deep_sleep_watchdog_req_in                     // [RQ1]
                  | low_freq_secondary_osc_en;                                       // [RQ2] [RQ15]
    end

    // ==========================================================
    // Base clock selection and edge ticks
    always @* begin
        sys_tick  = rise_of(sys_clk_level_in, sys_prev_ff);
        posc_tick = rise_of(primary_osc_level_in, posc_prev_ff);
        // System clock base tracks whatever source drives it
        base_tick  = ref_base ? posc_tick : sys_tick;              // [RQ7] [RQ11]
        base_level = ref_base ? primary_osc_level_in : sys_clk_level_in;
        // Sleep: system clock stops; primary stays only if kept
        if (sleep_in) begin
            ref_run = ref_en & ref_slp & ref_base & posc_mode
                    & posc_keep;                                   // [RQ8] [RQ9] [RQ10]
        end else begin
            ref_run = ref_en;                                      // [RQ5]
        end
    end

    lfro_divider #(
        .CNT_W         (DIV_W)
    ) u_div (
        .mclk_in       (mclk_in),
        .reset_in      (reset_in),
        .run_in        (ref_run),
        .code_in       (ref_div),
        .base_tick_in  (base_tick),
        .base_level_in (base_level),
        .clk_out       (div_clk)
    );

    // ==========================================================
    // Registered outputs
    always @(posedge mclk_in) begin
        if (reset_in) begin
            reg_rdata_out              <= 16'h0000;
            sys_prev_ff                <= 1'b0;
            posc_prev_ff               <= 1'b0;
            low_freq_secondary_osc_driver_en_out         <= 1'b0;
            low_freq_secondary_osc_clk_out               <= 1'b0;
            primary_osc_run_out        <= 1'b0;
            low_freq_secondary_osc_pin_digital_out       <= 2'h0;
            ref_clock_pin_out          <= 1'b0;
            ref_clock_pin_oe_out       <= 1'b0;
            fixed_clock_out_pin_out    <= 1'b0;
            fixed_clock_out_pin_oe_out <= 1'b0;
        end else begin
            reg_rdata_out <= nxt_rdata;
            sys_prev_ff   <= sys_clk_level_in;
            posc_prev_ff  <= primary_osc_level_in;
            // Digital mode: driver off, enable ignored
            low_freq_secondary_osc_driver_en_out <= low_freq_osc_pin_select_in
                                & ~ext_clock_mode_in & low_freq_secondary_osc_want;  // [RQ3] [RQ4]
            if (!low_freq_osc_pin_select_in) begin
                low_freq_secondary_osc_clk_out <= 1'b0;                              // [RQ3]
            end else if (ext_clock_mode_in) begin
                low_freq_secondary_osc_clk_out <= ext_low_freq_clock_in;             // [RQ4]
            end else begin
                low_freq_secondary_osc_clk_out <= low_freq_secondary_osc_crystal_level_in & low_freq_secondary_osc_want; // [RQ1]
            end
            low_freq_secondary_osc_pin_digital_out <= low_freq_osc_pin_select_in ? 2'h0
                                  : {low_freq_secondary_osc_pin_b_in, low_freq_secondary_osc_pin_a_in}; // [RQ3]
            primary_osc_run_out <= posc_mode & (~sleep_in | posc_keep); // [RQ16] [RQ10]
            ref_clock_pin_out    <= div_clk & ref_run;             // [RQ5]
            ref_clock_pin_oe_out <= ref_en;                        // [RQ13]
            // Fixed half-rate output toggles on each system clock rising edge when enabled, outside Sleep
            if (fixed_clock_out_mode_in & ~sleep_in & sys_tick) begin
                fixed_clock_out_pin_out <= ~fixed_clock_out_pin_out; // [RQ13]
            end
            fixed_clock_out_pin_oe_out <= fixed_clock_out_mode_in;
        end
    end

endmodule
`default_nettype wire

// [verification/lfro_ref_load.sv]
// Purpose: External load clocked from the reference pin
// Assumes: Pin sampled on each mclk edge
// Notes:   Lengths are in mclk cycles
`timescale 1ns/100ps
`default_nettype none
module lfro_ref_load (
    // Clock and pin
    input  wire logic        mclk_in,
    input  wire logic        pin_in,
    // Measured shape
    output var  logic [15:0] hi_len_out,
    output var  logic [15:0] lo_len_out,
    output var  logic [15:0] rises_out
);
    logic        last_ff = 1'b0;
    logic [15:0] run_ff = 16'h0000;
    initial {hi_len_out, lo_len_out, rises_out} = '0;
    // Whole spans only, so duty is judged fairly
    always @(posedge mclk_in) begin
        last_ff <= pin_in;
        run_ff <= (pin_in != last_ff) ? 16'h0001 : run_ff + 16'h0001;
        if (pin_in && !last_ff) begin
            lo_len_out <= run_ff;
            rises_out <= rises_out + 16'h0001;
        end
        if (!pin_in && last_ff)
            hi_len_out <= run_ff;
    end
endmodule
`default_nettype wire

// [verification/lfro_top_assertions.sv]
// Purpose: Port checks for lfro_top
// Assumes: Writes land one cycle after the strobe
// Notes:   Shadows two bits to judge Sleep gating
`timescale 1ns/100ps
`default_nettype none
module lfro_checker (
    // Clock, reset, register port
    input wire logic        mclk_in,
    input wire logic        reset_in,
    input wire logic [3:0]  reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    // Configuration and requests
    input wire logic        low_freq_osc_pin_select_in,
    input wire logic        ext_clock_mode_in,
    input wire logic        sleep_in,
    input wire logic        real_time_calendar_req_in,
    input wire logic        first_timer_req_in,
    input wire logic        deep_sleep_watchdog_req_in,
    // Outputs
    input wire logic        low_freq_secondary_osc_driver_en_out,
    input wire logic [1:0]  low_freq_secondary_osc_pin_digital_out,
    input wire logic        ref_clock_pin_out,
    input wire logic        ref_clock_pin_oe_out
);
    logic [1:0] slp_ff;
    wire logic  want = real_time_calendar_req_in | first_timer_req_in
                       | deep_sleep_watchdog_req_in;
    // ==========
    // Sleep-run and base select shadow
    always @(posedge mclk_in) begin
        if (reset_in)
            slp_ff <= 2'h0;
        else if (reg_wr_in && reg_addr_in == 4'h0)
            slp_ff <= reg_wdata_in[13:12];
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    AST_RSVD_ZERO:
        assert property (reg_rd_in && reg_addr_in == 4'h0 |=> !reg_rdata_out[14]
            && reg_rdata_out[7:0] == 8'h00) else $error("reserved bits set");
    AST_OE_WRITE:
        assert property (reg_wr_in && reg_addr_in == 4'h0 |-> ##2
            ref_clock_pin_oe_out == $past(reg_wdata_in[15], 2)) else $error("oe wrong");
    AST_PIN_OFF:
        assert property (!ref_clock_pin_oe_out [*3] |-> !ref_clock_pin_out) else $error("pin on");
    AST_REQ_OSC:
        assert property ((want && low_freq_osc_pin_select_in && !ext_clock_mode_in) [*3]
            |-> low_freq_secondary_osc_driver_en_out) else $error("request ignored");
    AST_EXT_OFF:
        assert property (ext_clock_mode_in [*3] |-> !low_freq_secondary_osc_driver_en_out) else $error("ext drv");
    AST_DIG_OFF:
        assert property (!low_freq_osc_pin_select_in [*3] |-> !low_freq_secondary_osc_driver_en_out)
            else $error("digital drv");
    AST_PINS_ZERO:
        assert property (low_freq_osc_pin_select_in [*3] |-> low_freq_secondary_osc_pin_digital_out == 2'h0)
            else $error("pins not zero");
    AST_SLEEP_REF:
        assert property ((sleep_in && slp_ff != 2'h3) [*5] |-> !ref_clock_pin_out)
            else $error("ref runs in sleep");
endmodule
bind lfro_top lfro_checker lfro_checker_inst (.mclk_in, .reset_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .low_freq_osc_pin_select_in,
    .ext_clock_mode_in, .sleep_in, .real_time_calendar_req_in, .first_timer_req_in,
    .deep_sleep_watchdog_req_in, .low_freq_secondary_osc_driver_en_out, .low_freq_secondary_osc_pin_digital_out,
    .ref_clock_pin_out, .ref_clock_pin_oe_out);
`default_nettype wire

// [verification/testbench.sv]
// Purpose: Self-checking bench for lfro_top
// Assumes: Read data one cycle after the strobe
// Notes:   Slow base patterns keep ratios short
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        mclk_in, reset_in, reg_wr_in, reg_rd_in, sleep_in, fixed_clock_out_mode_in;
    logic        low_freq_osc_pin_select_in, ext_clock_mode_in, low_freq_secondary_osc_pin_a_in, low_freq_secondary_osc_pin_b_in;
    logic        real_time_calendar_req_in, first_timer_req_in, deep_sleep_watchdog_req_in;
    logic        sys_clk_level_in, primary_osc_level_in, low_freq_secondary_osc_crystal_level_in, e;
    logic        ext_low_freq_clock_in, low_freq_secondary_osc_driver_en_out, low_freq_secondary_osc_clk_out, primary_osc_run_out;
    logic        ref_clock_pin_out, ref_clock_pin_oe_out, ext_seen, cry_seen;
    logic        fixed_clock_out_pin_out, fixed_clock_out_pin_oe_out;
    logic [1:0]  primary_mode_in, low_freq_secondary_osc_pin_digital_out;
    logic [3:0]  reg_addr_in, ph;
    logic [15:0] reg_wdata_in, reg_rdata_out, hi_len, lo_len, rises, r;
    int          seed = 82591, mismatches = 0, n_tests = 0, h, d;

    lfro_top lfro_top_inst (.*);
    lfro_ref_load lfro_ref_load_inst (.mclk_in, .pin_in(ref_clock_pin_out),
        .hi_len_out(hi_len), .lo_len_out(lo_len), .rises_out(rises));

    always #5 mclk_in = ~mclk_in;
    // ==========
    // Base clocks: system period 4, primary period 6
    always @(posedge mclk_in) begin
        ph <= (ph == 4'hb) ? 4'h0 : ph + 4'h1;
        sys_clk_level_in <= ph[1];
        primary_osc_level_in <= (ph % 6) < 3;
        low_freq_secondary_osc_crystal_level_in <= ph[3];
        ext_low_freq_clock_in <= 1'($random(seed));
        // Levels as the design samples them at this edge
        {cry_seen, ext_seen} <= {low_freq_secondary_osc_crystal_level_in, ext_low_freq_clock_in};
    end

    function automatic int half(input logic [3:0] n, input logic sel);
        return (n == 4'h0) ? (sel ? 3 : 2) : (sel ? 6 : 4) << (n - 4'h1);
    endfunction
    task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
        n_tests++;
        if (g !== x) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] x, input string nm);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 chk(nm, x, reg_rdata_out);
    endtask
    // Counts pin rises, stops early at three
    task automatic see(input int lim);
        logic [15:0] r0;
        r0 = rises;
        d = 0;
        for (int i = 0; i < lim && d < 3; i++) begin
            @(posedge mclk_in);
            d = int'(rises - r0);
        end
    endtask
    task automatic sl(input logic [15:0] rv, input logic k, input logic x);
        wr(4'h0, rv);
        wr(4'h1, {13'h0, k, 2'h0});
        sleep_in <= 1'b1;
        repeat (20) @(posedge mclk_in);
        see(100);
        #1 chk("sleep ref", 16'(x), 16'(d >= 3));
        chk("sleep primary", 16'(k), 16'(primary_osc_run_out));
        @(posedge mclk_in);
        sleep_in <= 1'b0;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        {mclk_in, reg_wr_in, reg_rd_in, sleep_in, ext_clock_mode_in, e} = '0;
        {real_time_calendar_req_in, first_timer_req_in, deep_sleep_watchdog_req_in} = '0;
        {low_freq_secondary_osc_pin_a_in, low_freq_secondary_osc_pin_b_in, ph, reg_addr_in, reg_wdata_in, r} = '0;
        {sys_clk_level_in, primary_osc_level_in, low_freq_secondary_osc_crystal_level_in} = '0;
        {ext_low_freq_clock_in, fixed_clock_out_mode_in} = '0;
        {reset_in, low_freq_osc_pin_select_in} = 2'h3;
        primary_mode_in = 2'h2;
        repeat (20) @(posedge mclk_in);
        reset_in <= 1'b0;
        rd(4'h0, 16'h0000, "ref reset");
        rd(4'h2, 16'h0008, "status reset");
        wr(4'h1, 16'hffff);
        rd(4'h1, 16'h0006, "osc bits");
        wr(4'h0, 16'hffff);
        rd(4'h0, 16'hbf00, "ref bits");
        wr(4'h3, 16'hffff);
        rd(4'h3, 16'h0000, "unmapped");
        $display("register test done");
        repeat (30) begin
            r = 16'($random(seed));
            wr(4'h1, {14'h0, r[9], 1'b0});
            {real_time_calendar_req_in, first_timer_req_in, deep_sleep_watchdog_req_in} <= r[2:0];
            low_freq_osc_pin_select_in <= r[3] | r[4];
            ext_clock_mode_in <= r[5] & r[6];
            {low_freq_secondary_osc_pin_b_in, low_freq_secondary_osc_pin_a_in} <= r[8:7];
            fixed_clock_out_mode_in <= r[10];
            e = (r[9] | (|r[2:0])) & (r[3] | r[4]) & ~(r[5] & r[6]);
            repeat (5) @(posedge mclk_in);
            #1 chk("driver", 16'(e), 16'(low_freq_secondary_osc_driver_en_out));
            e = (r[3] | r[4]) & ((r[5] & r[6]) ? ext_seen : cry_seen & (r[9] | (|r[2:0])));
            chk("low_freq_secondary_osc clock", 16'(e), 16'(low_freq_secondary_osc_clk_out));
            chk("fixed oe", 16'(r[10]), 16'(fixed_clock_out_pin_oe_out));
            // One system clock rise in any four cycles: one toggle if enabled
            e = fixed_clock_out_pin_out;
            repeat (4) @(posedge mclk_in);
            #1 chk("fixed clock", 16'(e ^ r[10]), 16'(fixed_clock_out_pin_out));
            if (!(r[3] | r[4]))
                chk("pins", 16'(r[8:7]), 16'(low_freq_secondary_osc_pin_digital_out));
        end
        $display("oscillator test done");
        for (int n = 0; n < 16; n++) begin
            r = 16'($random(seed));
            h = half(4'(n), r[0]);
            wr(4'h0, 16'h0000);
            wr(4'h0, {3'b100, r[0], 4'(n), 8'h00});
            if (n < 10) begin
                see(8 * h + 60);
                chk("high", 16'(h), hi_len);
                chk("low", 16'(h), lo_len);
            end
        end
        $display("divider test done");
        sl(16'hb100, 1'b1, 1'b1);
        sl(16'hb100, 1'b0, 1'b0);
        sl(16'h9100, 1'b1, 1'b0);
        sl(16'ha100, 1'b1, 1'b0);
        $display("sleep test done");
        stop_test;
    end

    // Tests need about 15k cycles; cut off at 100k
    initial begin
        #1000000;
        mismatches++;
        stop_test;
    end
endmodule
`default_nettype wire
